/* File: rtl/slpl_link.sv */
// serial loader packet link: async port with auto baud, spi mode 3 slave,
// length/sum packets with ack and nak in both directions
// assumes i_ref_clk is the crystal clock and the uart and spi pins are asynchronous to it
`timescale 1ns/10ps
module slpl_link
(
    input  wire logic       i_ref_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_release,
    input  wire logic       i_uart_rx,
    output logic            o_uart_tx,
    input  wire logic       i_ssi_clk,
    input  wire logic       i_ssi_cs_n,
    input  wire logic       i_ssi_mosi,
    output logic            o_ssi_miso,
    output logic            o_ssi_miso_oe,
    input  wire logic       i_tx_wr,
    input  wire logic [7:0] i_tx_wdata,
    input  wire logic       i_tx_start,
    output logic            o_tx_ready,
    output logic            o_tx_ack,
    output logic            o_tx_nak,
    output logic [7:0]      o_rx_data,
    output logic            o_rx_valid,
    output logic            o_rx_good,
    output logic            o_rx_bad,
    output logic            o_port_uart,
    output logic            o_port_ssi,
    output logic [15:0]     o_baud_div
);

    slpl_pkg::slpl_state_t q;
    slpl_pkg::slpl_state_t d;
    logic [7:0]            tx_mem [0:255];

    logic       rx_fall;
    logic       sck_rise;
    logic       sck_fall;
    logic       cs_fall;
    logic       byte_v;
    logic [7:0] byte_rx;
    logic       want;
    logic [7:0] out_byte;
    logic       take;
    logic       ssi_end;
    logic [7:0] next_sum;

    always_comb
    begin
        rx_fall  = q.rx_s3 & ~q.rx_s2;
        sck_rise = ~q.sck_s3 & q.sck_s2;
        sck_fall = q.sck_s3 & ~q.sck_s2;
        cs_fall  = q.cs_s3 & ~q.cs_s2;
        ssi_end  = (q.port == slpl_pkg::PORT_SSI) & ~q.cs_s2 & sck_rise
                   & (q.s_bit == slpl_pkg::LAST_BIT);
        // next byte to send, chosen only from registered state
        want     = 1'b1;
        out_byte = slpl_pkg::ZERO_BYTE;
        if (q.sync_ack)
        begin
            out_byte = slpl_pkg::ACK_BYTE;
        end
        else
        begin
            unique case (q.st)
                slpl_pkg::PK_REPLY:   out_byte = q.ack_ok ? slpl_pkg::ACK_BYTE
                                                          : slpl_pkg::NAK_BYTE;
                slpl_pkg::PK_TX_LEN:  out_byte = q.tx_len;
                slpl_pkg::PK_TX_SUM:  out_byte = q.tx_sum;
                slpl_pkg::PK_TX_DATA: out_byte = tx_mem[q.cnt];
                default:              want = 1'b0;
            endcase
        end
        // spi takes a byte at every boundary so a started packet has no gaps
        take = want & (((q.port == slpl_pkg::PORT_UART) & q.baud_ok & ~q.utx_busy)
                       | ((q.port == slpl_pkg::PORT_SSI) & (ssi_end | cs_fall)));
        o_tx_ready = (q.st == slpl_pkg::PK_IDLE) & ~q.sync_ack
                     & ((q.port == slpl_pkg::PORT_SSI)
                        | ((q.port == slpl_pkg::PORT_UART) & q.baud_ok));
    end

    always_comb
    begin
        d          = q;
        d.rx_v     = 1'b0;
        d.rx_good  = 1'b0;
        d.rx_bad   = 1'b0;
        d.tx_ack   = 1'b0;
        d.tx_nak   = 1'b0;
        byte_v     = 1'b0;
        byte_rx    = slpl_pkg::ZERO_BYTE;
        next_sum   = q.sum + q.exp;
        // two flops per pin before any logic reads them
        d.rx_s1    = i_uart_rx;
        d.rx_s2    = q.rx_s1;
        d.rx_s3    = q.rx_s2;
        d.sck_s1   = i_ssi_clk;
        d.sck_s2   = q.sck_s1;
        d.sck_s3   = q.sck_s2;
        d.cs_s1    = i_ssi_cs_n;
        d.cs_s2    = q.cs_s1;
        d.cs_s3    = q.cs_s2;
        d.mosi_s1  = i_ssi_mosi;
        d.mosi_s2  = q.mosi_s1;

        // first activity claims the link
        if (q.port == slpl_pkg::PORT_NONE)
        begin
            if (cs_fall)
                d.port = slpl_pkg::PORT_SSI;
            else if (rx_fall)
                d.port = slpl_pkg::PORT_UART;
        end
        else if (i_release)
        begin
            d.port = slpl_pkg::PORT_NONE;
        end

        // rate detection: time edges 1 to 9 of the 0x55 0x55 pattern
        if (~q.baud_ok & (q.port != slpl_pkg::PORT_SSI))
        begin
            if ((q.edges >= slpl_pkg::EDGE_FIRST) & (q.edges < slpl_pkg::EDGE_SPAN))
                d.meas = q.meas + 20'h00001;
            if (rx_fall)
            begin
                d.edges = q.edges + 4'h1;
                if (q.edges == (slpl_pkg::EDGE_SPAN - 4'h1))
                    d.div = q.meas[slpl_pkg::MEAS_W-1:slpl_pkg::SPAN_SHIFT];
                if (q.edges == (slpl_pkg::EDGE_LAST - 4'h1))
                begin
                    // skip the tail of the second sync byte before decoding
                    d.baud_ok = 1'b1;
                    d.urx     = slpl_pkg::URX_HOLD;
                    d.urx_cnt = {q.div[slpl_pkg::DIV_W-2:0], 1'b0};
                end
            end
        end

        // async receiver, 8n1, samples at mid bit
        if (q.baud_ok & (q.port == slpl_pkg::PORT_UART))
        begin
            d.urx_cnt = q.urx_cnt - 16'h0001;
            unique case (q.urx)
                slpl_pkg::URX_IDLE:
                begin
                    d.urx_cnt = {1'b0, q.div[slpl_pkg::DIV_W-1:1]};
                    if (rx_fall)
                        d.urx = slpl_pkg::URX_START;
                end
                slpl_pkg::URX_START:
                    if (q.urx_cnt == 16'h0000)
                    begin
                        d.urx_cnt = q.div - 16'h0001;
                        d.urx_bit = 3'h0;
                        d.urx     = q.rx_s2 ? slpl_pkg::URX_IDLE : slpl_pkg::URX_DATA;
                    end
                slpl_pkg::URX_DATA:
                    if (q.urx_cnt == 16'h0000)
                    begin
                        d.urx_sh  = {q.rx_s2, q.urx_sh[7:1]};
                        d.urx_cnt = q.div - 16'h0001;
                        d.urx_bit = q.urx_bit + 3'h1;
                        if (q.urx_bit == slpl_pkg::LAST_BIT)
                            d.urx = slpl_pkg::URX_STOP;
                    end
                slpl_pkg::URX_STOP:
                    if (q.urx_cnt == 16'h0000)
                    begin
                        // no parity; a low stop bit drops the character
                        byte_v  = q.rx_s2;
                        byte_rx = q.urx_sh;
                        d.urx   = slpl_pkg::URX_IDLE;
                    end
                slpl_pkg::URX_HOLD:
                    if (q.urx_cnt == 16'h0000)
                    begin
                        d.urx      = slpl_pkg::URX_IDLE;
                        d.sync_ack = 1'b1;
                    end
            endcase
        end

        // async transmitter: start, 8 data lsb first, one stop
        if (q.utx_busy)
        begin
            d.utx_cnt = q.utx_cnt - 16'h0001;
            if (q.utx_cnt == 16'h0000)
            begin
                d.utx_cnt = q.div - 16'h0001;
                d.utx_sh  = {slpl_pkg::LINE_IDLE, q.utx_sh[9:1]};
                d.utx_bit = q.utx_bit + 4'h1;
                if (q.utx_bit == slpl_pkg::FRAME_LAST)
                    d.utx_busy = 1'b0;
            end
        end
        if (take & (q.port == slpl_pkg::PORT_UART))
        begin
            d.utx_busy = 1'b1;
            d.utx_cnt  = q.div - 16'h0001;
            d.utx_bit  = 4'h0;
            d.utx_sh   = {slpl_pkg::LINE_IDLE, out_byte, 1'b0};
        end

        // spi mode 3 slave: sample on rising edge, shift out on falling edge
        if ((q.port == slpl_pkg::PORT_SSI) & ~q.cs_s2)
        begin
            if (sck_rise)
            begin
                d.s_rx  = {q.s_rx[6:0], q.mosi_s2};
                d.s_bit = q.s_bit + 3'h1;
                if (q.s_bit == slpl_pkg::LAST_BIT)
                begin
                    byte_v  = 1'b1;
                    byte_rx = {q.s_rx[6:0], q.mosi_s2};
                end
            end
            if (sck_fall)
            begin
                d.miso = q.s_tx[7];
                d.s_tx = {q.s_tx[6:0], 1'b0};
            end
            // host owns the clock; idle bytes go out as zero fill
            if (ssi_end | cs_fall)
                d.s_tx = take ? out_byte : slpl_pkg::ZERO_BYTE;
        end
        else
        begin
            d.s_bit = 3'h0;
        end

        if (take & q.sync_ack)
            d.sync_ack = 1'b0;

        // packet layer
        unique case (q.st)
            slpl_pkg::PK_IDLE:
            begin
                if (i_tx_wr & (q.wptr < slpl_pkg::MAX_PAYLOAD))
                begin
                    d.wptr   = q.wptr + 8'h01;
                    d.tx_sum = q.tx_sum + i_tx_wdata;
                end
                if (byte_v & (byte_rx != slpl_pkg::ZERO_BYTE))
                begin
                    d.len = byte_rx;
                    d.sum = slpl_pkg::ZERO_BYTE;
                    d.cnt = slpl_pkg::HDR_BYTES;
                    if (byte_rx < slpl_pkg::HDR_BYTES)
                    begin
                        d.ack_ok = 1'b0;
                        d.st     = slpl_pkg::PK_REPLY;
                    end
                    else
                    begin
                        d.st = slpl_pkg::PK_SUM;
                    end
                end
                else if (i_tx_start & o_tx_ready)
                begin
                    d.tx_len = q.wptr + slpl_pkg::HDR_BYTES;
                    d.wptr   = slpl_pkg::ZERO_BYTE;
                    d.cnt    = slpl_pkg::ZERO_BYTE;
                    d.st     = slpl_pkg::PK_TX_LEN;
                end
            end
            slpl_pkg::PK_SUM:
                if (byte_v)
                begin
                    d.exp = byte_rx;
                    if (q.len == slpl_pkg::HDR_BYTES)
                    begin
                        d.ack_ok = (byte_rx == slpl_pkg::ZERO_BYTE);
                        d.st     = slpl_pkg::PK_REPLY;
                    end
                    else
                    begin
                        d.st = slpl_pkg::PK_DATA;
                    end
                end
            slpl_pkg::PK_DATA:
                if (byte_v)
                begin
                    next_sum  = q.sum + byte_rx;
                    d.sum     = next_sum;
                    d.rx_v    = 1'b1;
                    d.rx_data = byte_rx;
                    d.cnt     = q.cnt + 8'h01;
                    if (q.cnt == (q.len - 8'h01))
                    begin
                        d.ack_ok = (next_sum == q.exp);
                        d.st     = slpl_pkg::PK_REPLY;
                    end
                end
            slpl_pkg::PK_REPLY:
                if (take)
                begin
                    d.rx_good = q.ack_ok;
                    d.rx_bad  = ~q.ack_ok;
                    d.st      = slpl_pkg::PK_IDLE;
                end
            slpl_pkg::PK_TX_LEN:
                if (take)
                    d.st = slpl_pkg::PK_TX_SUM;
            slpl_pkg::PK_TX_SUM:
                if (take)
                    d.st = (q.tx_len == slpl_pkg::HDR_BYTES) ? slpl_pkg::PK_TX_ACK
                                                             : slpl_pkg::PK_TX_DATA;
            slpl_pkg::PK_TX_DATA:
                if (take)
                begin
                    d.cnt = q.cnt + 8'h01;
                    if (q.cnt == (q.tx_len - 8'h03))
                    begin
                        d.tx_sum = slpl_pkg::ZERO_BYTE;
                        d.st     = slpl_pkg::PK_TX_ACK;
                    end
                end
            slpl_pkg::PK_TX_ACK:
                // anything non-zero other than ack counts as a refusal
                if (byte_v & (byte_rx != slpl_pkg::ZERO_BYTE))
                begin
                    d.tx_ack = (byte_rx == slpl_pkg::ACK_BYTE);
                    d.tx_nak = (byte_rx != slpl_pkg::ACK_BYTE);
                    d.tx_sum = slpl_pkg::ZERO_BYTE;
                    d.st     = slpl_pkg::PK_IDLE;
                end
        endcase
    end

    // clocked from the crystal only; every timing above scales from it
    always_ff @(posedge i_ref_clk)
    begin
        if (!i_reset_n)
        begin
            q        <= '0;
            q.rx_s1  <= slpl_pkg::LINE_IDLE;
            q.rx_s2  <= slpl_pkg::LINE_IDLE;
            q.rx_s3  <= slpl_pkg::LINE_IDLE;
            q.sck_s1 <= slpl_pkg::LINE_IDLE;
            q.sck_s2 <= slpl_pkg::LINE_IDLE;
            q.sck_s3 <= slpl_pkg::LINE_IDLE;
            q.cs_s1  <= slpl_pkg::LINE_IDLE;
            q.cs_s2  <= slpl_pkg::LINE_IDLE;
            q.cs_s3  <= slpl_pkg::LINE_IDLE;
            q.utx_sh <= '1;
        end
        else
        begin
            q <= d;
        end
    end

    // payload staging; no reset needed, contents are written before use
    always_ff @(posedge i_ref_clk)
    begin
        if ((q.st == slpl_pkg::PK_IDLE) & i_tx_wr & (q.wptr < slpl_pkg::MAX_PAYLOAD))
            tx_mem[q.wptr] <= i_tx_wdata;
    end

    assign o_uart_tx     = q.utx_sh[0];
    assign o_ssi_miso    = q.miso;
    assign o_ssi_miso_oe = (q.port == slpl_pkg::PORT_SSI) & ~q.cs_s2;
    assign o_tx_ack      = q.tx_ack;
    assign o_tx_nak      = q.tx_nak;
    assign o_rx_data     = q.rx_data;
    assign o_rx_valid    = q.rx_v;
    assign o_rx_good     = q.rx_good;
    assign o_rx_bad      = q.rx_bad;
    assign o_port_uart   = (q.port == slpl_pkg::PORT_UART);
    assign o_port_ssi    = (q.port == slpl_pkg::PORT_SSI);
    assign o_baud_div    = q.div;

endmodule : slpl_link

/* File: rtl/slpl_pkg.sv */
// constants and types of the serial loader packet link
// assumes one 100 MHz crystal-derived clock, no pll, and a synchronous low reset
package slpl_pkg;

    localparam logic [7:0]  SYNC_BYTE    = 8'h55;
    localparam logic [7:0]  ACK_BYTE     = 8'hCC;
    localparam logic [7:0]  NAK_BYTE     = 8'h33;
    localparam logic [7:0]  ZERO_BYTE    = 8'h00;
    localparam logic [7:0]  HDR_BYTES    = 8'h02;
    localparam logic [7:0]  MAX_PAYLOAD  = 8'hFD;
    localparam int          DIV_W        = 16;
    localparam int          MEAS_W       = 20;
    // falling edges 1 to 9 of the two sync bytes span sixteen bit times
    localparam logic [3:0]  EDGE_FIRST   = 4'h1;
    localparam logic [3:0]  EDGE_SPAN    = 4'h9;
    localparam logic [3:0]  EDGE_LAST    = 4'hA;
    localparam int          SPAN_SHIFT   = 4;
    localparam logic [2:0]  LAST_BIT     = 3'h7;
    localparam logic [3:0]  FRAME_LAST   = 4'h9;
    localparam logic        LINE_IDLE    = 1'b1;

    typedef enum logic [1:0] {PORT_NONE, PORT_UART, PORT_SSI} slpl_port_t;
    typedef enum logic [2:0] {URX_IDLE, URX_START, URX_DATA, URX_STOP, URX_HOLD} slpl_urx_t;
    typedef enum logic [2:0] {PK_IDLE, PK_SUM, PK_DATA, PK_REPLY,
                              PK_TX_LEN, PK_TX_SUM, PK_TX_DATA, PK_TX_ACK} slpl_pkt_t;

    typedef struct packed {
        slpl_port_t             port;
        logic                   rx_s1;
        logic                   rx_s2;
        logic                   rx_s3;
        logic                   sck_s1;
        logic                   sck_s2;
        logic                   sck_s3;
        logic                   cs_s1;
        logic                   cs_s2;
        logic                   cs_s3;
        logic                   mosi_s1;
        logic                   mosi_s2;
        logic [3:0]             edges;
        logic [MEAS_W-1:0]      meas;
        logic [DIV_W-1:0]       div;
        logic                   baud_ok;
        logic                   sync_ack;
        slpl_urx_t              urx;
        logic [DIV_W-1:0]       urx_cnt;
        logic [2:0]             urx_bit;
        logic [7:0]             urx_sh;
        logic                   utx_busy;
        logic [DIV_W-1:0]       utx_cnt;
        logic [3:0]             utx_bit;
        logic [9:0]             utx_sh;
        logic [2:0]             s_bit;
        logic [7:0]             s_rx;
        logic [7:0]             s_tx;
        logic                   miso;
        slpl_pkt_t              st;
        logic [7:0]             len;
        logic [7:0]             cnt;
        logic [7:0]             exp;
        logic [7:0]             sum;
        logic                   ack_ok;
        logic [7:0]             wptr;
        logic [7:0]             tx_len;
        logic [7:0]             tx_sum;
        logic                   rx_v;
        logic [7:0]             rx_data;
        logic                   rx_good;
        logic                   rx_bad;
        logic                   tx_ack;
        logic                   tx_nak;
    } slpl_state_t;

endpackage : slpl_pkg

/* File: tb/slpl_host_model.sv */
// host side model of the async loader port: 8n1 sender and receiver
// assumes the device pin idles high; BIT_NS sets the host bit time
`timescale 1ns/10ps
module slpl_host_model
#(
    parameter int BIT_NS = 645 // slower than crystal over 32
)
(
    output logic      o_rx_line,
    input  wire logic i_tx_line
);
    logic [8:0] rx_q[$];
    logic [8:0] sh;
    initial o_rx_line = 1'b1;
    // a low stop bit is sent only where a dropped character is wanted
    task send_byte(input logic [7:0] b, input logic stop);
        o_rx_line = 1'b0;
        for (int i = 0; i < 9; i++)
        begin
            #(BIT_NS);
            o_rx_line = (i < 8) ? b[i] : stop;
        end
        #(BIT_NS);
        // low stop needs an idle bit, else the next start has no edge
        if (!stop)
        begin
            o_rx_line = 1'b1;
            #(BIT_NS);
        end
    endtask : send_byte
    // mid-bit sampling; word kept as stop bit over data
    always @(negedge i_tx_line)
    begin
        #(BIT_NS / 2);
        for (int i = 0; i < 9; i++)
        begin
            #(BIT_NS);
            sh = {i_tx_line, sh[8:1]};
        end
        rx_q.push_back(sh);
    end
endmodule : slpl_host_model

/* File: tb/slpl_link_checker.sv */
// assertions on the loader link ports
// assumes the single crystal clock domain and the synchronous low reset
`timescale 1ns/10ps
module slpl_link_checker
(
    input wire logic        i_ref_clk,
    input wire logic        i_reset_n,
    input wire logic        i_release,
    input wire logic        i_ssi_clk,
    input wire logic        o_uart_tx,
    input wire logic        o_ssi_miso,
    input wire logic        o_ssi_miso_oe,
    input wire logic        o_tx_ack,
    input wire logic        o_tx_nak,
    input wire logic        o_rx_good,
    input wire logic        o_rx_bad,
    input wire logic        o_port_uart,
    input wire logic        o_port_ssi,
    input wire logic [15:0] o_baud_div
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    // low run of the tx pin; inside a frame only whole bit times are legal
    logic [19:0] low_q;
    logic [19:0] low_d;
    always_comb low_d = o_uart_tx ? 20'h00000 : low_q + 20'h00001;
    always_ff @(posedge i_ref_clk) low_q <= i_reset_n ? low_d : 20'h00000;

    property p_reset_idle;
        $rose(i_reset_n) |-> o_uart_tx && !o_port_uart && !o_port_ssi && o_baud_div == 16'h0000;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
    property p_one_port; !(o_port_uart && o_port_ssi); endproperty
    a_one_port: assert property (p_one_port) else $error("both ports locked");
    property p_lock_hold;
        (o_port_uart || o_port_ssi) && !i_release |=> $stable({o_port_uart, o_port_ssi});
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("port lock lost");
    property p_oe_port; o_ssi_miso_oe |-> o_port_ssi; endproperty
    a_oe_port: assert property (p_oe_port) else $error("miso driven while unlocked");
    property p_ack_pulse;
        o_tx_ack || o_tx_nak |-> !(o_tx_ack && o_tx_nak) ##1 (!o_tx_ack && !o_tx_nak);
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("bad reply pulse");
    property p_good_bad;
        o_rx_good || o_rx_bad |-> !(o_rx_good && o_rx_bad) ##1 (!o_rx_good && !o_rx_bad);
    endproperty
    a_good_bad: assert property (p_good_bad) else $error("bad verdict pulse");
    property p_low_run;
        $rose(o_uart_tx) && o_port_uart && o_baud_div != 16'h0000
            |-> low_q != 20'h00000 && low_q % {4'h0, o_baud_div} == 20'h00000;
    endproperty
    a_low_run: assert property (p_low_run) else $error("tx bit time off");
    property p_good_tx; o_rx_good && o_port_uart |-> ##[0:8] !o_uart_tx; endproperty
    a_good_tx: assert property (p_good_tx) else $error("ack not sent");
    property p_miso_fall;
        o_ssi_miso_oe && $past(o_ssi_miso_oe) && $changed(o_ssi_miso) |-> !$past(i_ssi_clk, 2);
    endproperty
    a_miso_fall: assert property (p_miso_fall) else $error("miso moved off falling sck");
endmodule : slpl_link_checker

bind slpl_link slpl_link_checker slpl_link_checker_i
(
    .i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n), .i_release(i_release),
    .i_ssi_clk(i_ssi_clk), .o_uart_tx(o_uart_tx), .o_ssi_miso(o_ssi_miso),
    .o_ssi_miso_oe(o_ssi_miso_oe), .o_tx_ack(o_tx_ack), .o_tx_nak(o_tx_nak),
    .o_rx_good(o_rx_good), .o_rx_bad(o_rx_bad), .o_port_uart(o_port_uart),
    .o_port_ssi(o_port_ssi), .o_baud_div(o_baud_div)
);

/* File: tb/slpl_link_test.sv */
// self-checking bench of the loader link with random payloads
// assumes the async host model and the bound checker are compiled first
`timescale 1ns/10ps
module slpl_link_test;
    localparam int BIT_NS = 645;
    logic        ref_clk  = 1'b0;
    logic        reset_n  = 1'b0;
    logic        unlock   = 1'b0;
    logic        ssi_clk  = 1'b1;
    logic        ssi_cs_n = 1'b1;
    logic        ssi_mosi = 1'b0;
    logic        tx_wr    = 1'b0;
    logic [7:0]  tx_wdata = 8'h00;
    logic        tx_start = 1'b0;
    logic        uart_rx, uart_tx, ssi_miso, miso_oe, tx_ready, tx_ack, tx_nak;
    logic        rx_valid, rx_good, rx_bad, port_uart, port_ssi;
    logic [7:0]  rx_data;
    logic [15:0] baud_div;
    logic [31:0] seed = 32'h3473;
    logic [7:0]  pay[$];
    logic [7:0]  rxq[$];
    int          mismatches = 0;
    int          cmp_count = 0;
    int          n_good = 0, n_bad = 0, n_ack = 0, n_nak = 0;

    always #5 ref_clk = ~ref_clk;
    slpl_host_model #(.BIT_NS(BIT_NS)) slpl_host_model_i (.o_rx_line(uart_rx), .i_tx_line(uart_tx));
    slpl_link slpl_link_i
    (
        .i_ref_clk(ref_clk), .i_reset_n(reset_n), .i_release(unlock), .i_uart_rx(uart_rx),
        .o_uart_tx(uart_tx), .i_ssi_clk(ssi_clk), .i_ssi_cs_n(ssi_cs_n), .i_ssi_mosi(ssi_mosi),
        .o_ssi_miso(ssi_miso), .o_ssi_miso_oe(miso_oe), .i_tx_wr(tx_wr), .i_tx_wdata(tx_wdata),
        .i_tx_start(tx_start), .o_tx_ready(tx_ready), .o_tx_ack(tx_ack), .o_tx_nak(tx_nak),
        .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_good(rx_good), .o_rx_bad(rx_bad),
        .o_port_uart(port_uart), .o_port_ssi(port_ssi), .o_baud_div(baud_div)
    );
    always @(posedge ref_clk)
    begin
        if (rx_valid === 1'b1)
            rxq.push_back(rx_data);
        n_good = n_good + int'(rx_good === 1'b1);
        n_bad = n_bad + int'(rx_bad === 1'b1);
        n_ack = n_ack + int'(tx_ack === 1'b1);
        n_nak = n_nak + int'(tx_nak === 1'b1);
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // eight-bit wrap is intended
    function automatic logic [7:0] sum_of();
        logic [7:0] s;
        s = 8'h00;
        foreach (pay[i]) s = s + pay[i];
        return s;
    endfunction : sum_of
    function automatic logic [15:0] ports();
        return {14'h0000, port_uart, port_ssi};
    endfunction : ports
    task end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_sim
    task chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // waits for a device byte; stop bit must read high
    task expect_byte(input logic [7:0] e);
        int n;
        n = 0;
        while (slpl_host_model_i.rx_q.size() == 0 && n < 20000)
        begin
            @(posedge ref_clk);
            n++;
        end
        if (n == 20000)
        begin
            mismatches++;
            end_sim();
        end
        else
            chk({7'h00, slpl_host_model_i.rx_q.pop_front()}, {8'h01, e});
    endtask : expect_byte
    // mode 3 host byte, 160 ns sck period keeps under crystal over 12
    task ssi_xfer(input logic [7:0] mo, output logic [7:0] mi);
        for (int i = 7; i >= 0; i--)
        begin
            ssi_clk = 1'b0;
            ssi_mosi = mo[i];
            #80;
            ssi_clk = 1'b1;
            mi[i] = ssi_miso;
            #80;
        end
    endtask : ssi_xfer
    initial
    begin
        int n;
        int g;
        int b;
        logic [7:0] s;
        logic [7:0] mi;
        repeat (2) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        repeat (2) slpl_host_model_i.send_byte(8'h55, 1'b1);
        expect_byte(8'hCC);
        chk(baud_div, 16'(BIT_NS / 10));
        chk(ports(), 16'h0002);
        ssi_cs_n = 1'b0;
        ssi_xfer(8'h55, mi);
        chk({15'h0000, miso_oe}, 16'h0000);
        ssi_cs_n = 1'b1;
        chk(ports(), 16'h0002);
        slpl_host_model_i.send_byte(8'h07, 1'b0);
        for (int k = 0; k < 6; k++)
        begin
            pay.delete();
            rxq.delete();
            n = (k == 0) ? 0 : (k == 1) ? 4 : int'(rnd() % 32'h5);
            for (int i = 0; i < n; i++)
                pay.push_back((k == 1) ? 8'hFF : 8'(rnd()));
            s = sum_of();
            g = n_good;
            b = n_bad;
            slpl_host_model_i.send_byte(8'h00, 1'b1);
            slpl_host_model_i.send_byte(8'(n + 2), 1'b1);
            slpl_host_model_i.send_byte((k == 3) ? s + 8'h01 : s, 1'b1);
            foreach (pay[i]) slpl_host_model_i.send_byte(pay[i], 1'b1);
            expect_byte((k == 3) ? 8'h33 : 8'hCC);
            chk(16'(n_good - g), (k == 3) ? 16'h0000 : 16'h0001);
            chk(16'(n_bad - b), (k == 3) ? 16'h0001 : 16'h0000);
            for (int i = 0; i < n && k != 3; i++)
                chk({8'h00, rxq[i]}, {8'h00, pay[i]});
        end
        for (int k = 0; k < 2; k++)
        begin
            pay.delete();
            n = 1 + int'(rnd() % 32'h3);
            @(posedge ref_clk);
            #1;
            chk({15'h0000, tx_ready}, 16'h0001);
            for (int i = 0; i < n; i++)
            begin
                pay.push_back(8'(rnd()));
                tx_wr = 1'b1;
                tx_wdata = pay[i];
                @(posedge ref_clk);
                #1;
            end
            tx_wr = 1'b0;
            tx_start = 1'b1;
            @(posedge ref_clk);
            #1 tx_start = 1'b0;
            expect_byte(8'(n + 2));
            expect_byte(sum_of());
            foreach (pay[i]) expect_byte(pay[i]);
            g = n_ack;
            b = n_nak;
            slpl_host_model_i.send_byte(8'h00, 1'b1);
            slpl_host_model_i.send_byte((k == 0) ? 8'hCC : 8'h33, 1'b1);
            repeat (8) @(posedge ref_clk);
            chk({8'(n_ack - g), 8'(n_nak - b)}, (k == 0) ? 16'h0100 : 16'h0001);
        end
        #1 unlock = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1 chk(ports(), 16'h0000);
        unlock = 1'b0;
        rxq.delete();
        ssi_cs_n = 1'b0;
        #200;
        ssi_xfer(8'h03, mi);
        ssi_xfer(8'h20, mi);
        ssi_xfer(8'h20, mi);
        mi = 8'h00;
        for (int i = 0; i < 4 && mi == 8'h00; i++)
            ssi_xfer(8'h00, mi);
        chk({8'h00, mi}, 16'h00CC);
        chk({8'h00, rxq[0]}, 16'h0020);
        ssi_cs_n = 1'b1;
        ssi_mosi = ~ssi_mosi;
        slpl_host_model_i.send_byte(8'h55, 1'b1);
        chk(ports(), 16'h0001);
        reset_n = 1'b0;
        repeat (2) @(posedge ref_clk);
        #1 reset_n = 1'b1;
        @(posedge ref_clk);
        #1 chk(ports(), 16'h0000);
        end_sim();
    end
endmodule : slpl_link_test
